/* File: rh_port_pkg.sv */
// Package with register layout, timing counts and carrier types for the root hub port logic.
package rh_port_pkg;

  localparam int unsigned NUM_PORTS = 2;
  localparam logic [7:0] PORT_STATUS_BASE = 8'h54;
  localparam logic [7:0] PORT_STATUS_STRIDE = 8'h04;
  localparam logic [31:0] PORT_STATUS_RESET = 32'h0000_0000;

  // Field positions of the port status and control word.
  localparam int unsigned BIT_CONNECTED = 0;
  localparam int unsigned BIT_ENABLED = 1;
  localparam int unsigned BIT_SUSPENDED = 2;
  localparam int unsigned BIT_OVERCURRENT = 3;
  localparam int unsigned BIT_RESET_ACTIVE = 4;
  localparam int unsigned BIT_POWER_ON = 8;
  localparam int unsigned BIT_LOW_SPEED = 9;
  localparam int unsigned BIT_CONNECT_CHG = 16;
  localparam int unsigned BIT_ENABLE_CHG = 17;
  localparam int unsigned BIT_SUSPEND_CHG = 18;
  localparam int unsigned BIT_OVERCURRENT_CHG = 19;
  localparam int unsigned BIT_RESET_DONE_CHG = 20;

  // Timing at the 25 MHz core clock.
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PORT_RESET_MS = 10;
  localparam int unsigned RESUME_PULSE_MS = 20;
  localparam int unsigned RESYNC_MS = 3;
  localparam int unsigned LS_EOP_CYCLES_MIN = 1;
  localparam int unsigned PORT_RESET_CYCLES = (CLK_HZ / 1000) * PORT_RESET_MS;
  localparam int unsigned RESUME_PULSE_CYCLES = (CLK_HZ / 1000) * RESUME_PULSE_MS;
  localparam int unsigned RESYNC_CYCLES = (CLK_HZ / 1000) * RESYNC_MS;
  localparam int unsigned LS_EOP_MS_NUM = 0;
  localparam int unsigned TIMER_W = 20;

  typedef enum logic [1:0] {
    SIG_IDLE   = 2'b00,
    SIG_RESET  = 2'b01,
    SIG_RESUME = 2'b10,
    SIG_RESYNC = 2'b11
  } sig_state_e;

  // Write commands decoded from one register write.
  typedef struct packed {
    logic clr_enable;
    logic set_enable;
    logic set_suspend;
    logic resume;
    logic set_reset;
    logic set_power;
    logic clr_power;
    logic [4:0] chg_clear;
  } port_cmd_s;

  // Line state seen from the transceiver of one port.
  typedef struct packed {
    logic connected;
    logic low_speed;
    logic overcurrent;
    logic bus_error;
  } port_line_s;

  // Signalling requests towards the transceiver.
  typedef struct packed {
    logic drive_reset;
    logic drive_resume;
    logic drive_ls_eop;
    logic power_on;
    logic enabled;
    logic suspended;
  } port_drive_s;

  // Hub-wide configuration that gates the port logic.
  typedef struct packed {
    logic no_power_switch;
    logic per_port_power;
    logic no_oc_protect;
    logic per_port_oc;
  } hub_cfg_s;

  function automatic port_cmd_s decode_write(input logic [31:0] d);
    port_cmd_s c;
    c.clr_enable = d[BIT_CONNECTED];
    c.set_enable = d[BIT_ENABLED];
    c.set_suspend = d[BIT_SUSPENDED];
    c.resume = d[BIT_OVERCURRENT];
    c.set_reset = d[BIT_RESET_ACTIVE];
    c.set_power = d[BIT_POWER_ON];
    c.clr_power = d[BIT_LOW_SPEED];
    c.chg_clear = d[BIT_RESET_DONE_CHG:BIT_CONNECT_CHG];
    return c;
  endfunction

endpackage

/* File: rh_port_slot.sv */
// One downstream port: status bits, change flags and reset/resume signalling timers.
`timescale 1ns/1ps
module rh_port_slot
  import rh_port_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // Configuration.
  input  wire hub_cfg_s    i_cfg,
  input  wire logic        i_power_mask,
  input  wire logic        i_non_removable,
  input  wire logic        i_hub_reset_done,
  input  wire logic        i_hc_resume,
  // Commands; register writes already held back while a transaction runs, global on/off passed straight through.
  input  wire logic        i_cmd_valid,
  input  wire port_cmd_s   i_cmd,
  input  wire logic        i_global_on,
  input  wire logic        i_global_off,
  // Synchronised line state.
  input  wire port_line_s  i_line,
  // Status word and drive requests.
  output logic [31:0]      o_status,
  output port_drive_s      o_drive
);

  typedef struct packed {
    logic             connected;
    logic             enabled;
    logic             suspended;
    logic             oc;
    logic             reset_active;
    logic             power_on;
    logic             low_speed;
    logic [4:0]       chg;
    sig_state_e       sig;
    logic [TIMER_W-1:0] timer;
  } slot_s;

  slot_s st_r;
  slot_s st_nxt;
  logic  conn_now;
  logic  pwr_per_port;
  logic  pwr_on_cmd;
  logic  pwr_off_cmd;
  logic  hw_disable;
  logic [4:0] chg_keep;

  assign conn_now = i_non_removable | i_line.connected;
  assign pwr_per_port = i_cfg.per_port_power & i_power_mask;
  // Per-port commands only when per-port power is configured and the mask selects them, global ones otherwise.
  assign pwr_on_cmd = pwr_per_port ? (i_cmd_valid & i_cmd.set_power) : i_global_on;
  assign pwr_off_cmd = pwr_per_port ? (i_cmd_valid & i_cmd.clr_power) : i_global_off;

  always_comb begin
    st_nxt = st_r;
    hw_disable = 1'b0;
    // Hardware set events collect in a fresh vector, so an event that repeats on a set flag still beats a clear.
    st_nxt.chg = '0;
    chg_keep = st_r.chg;
    if (st_r.timer != '0) begin
      st_nxt.timer = st_r.timer - 1'b1;
    end
    // Connection tracking; a non-removable port only reports after a hub reset.
    if (i_non_removable) begin
      if (i_hub_reset_done) begin
        st_nxt.chg[0] = 1'b1;
      end
    end else if (st_r.power_on && (conn_now != st_r.connected)) begin
      st_nxt.chg[0] = 1'b1;
    end
    st_nxt.connected = st_r.power_on & conn_now;
    st_nxt.low_speed = st_nxt.connected & i_line.low_speed;
    if (i_cfg.per_port_oc && !i_cfg.no_oc_protect) begin
      if (i_line.overcurrent != st_r.oc) begin
        st_nxt.chg[3] = 1'b1;
      end
      st_nxt.oc = i_line.overcurrent;
    end else begin
      st_nxt.oc = 1'b0;
    end
    if (st_r.enabled && (!conn_now || i_line.overcurrent || i_line.bus_error)) begin
      hw_disable = 1'b1;
    end
    // Signalling sequencer.
    unique case (st_r.sig)
      SIG_IDLE: begin
      end
      SIG_RESET: begin
        if (st_r.timer == '0) begin
          st_nxt.sig = SIG_IDLE;
          st_nxt.reset_active = 1'b0;
          st_nxt.chg[4] = 1'b1;
          chg_keep[2] = 1'b0;
          st_nxt.suspended = 1'b0;
          st_nxt.enabled = st_nxt.connected;
        end
      end
      SIG_RESUME: begin
        if (st_r.timer == '0) begin
          st_nxt.sig = SIG_RESYNC;
          st_nxt.timer = TIMER_W'(RESYNC_CYCLES);
        end
      end
      SIG_RESYNC: begin
        if (st_r.timer == '0) begin
          st_nxt.sig = SIG_IDLE;
          st_nxt.suspended = 1'b0;
          st_nxt.chg[2] = 1'b1;
          st_nxt.enabled = st_nxt.connected;
        end
      end
    endcase
    if (i_hc_resume) begin
      st_nxt.suspended = 1'b0;
    end
    // Software commands.
    if (i_cmd_valid) begin
      if (i_cmd.clr_enable) begin
        st_nxt.enabled = 1'b0;
      end
      if (i_cmd.set_enable) begin
        if (conn_now) begin
          st_nxt.enabled = 1'b1;
        end else begin
          st_nxt.chg[0] = 1'b1;
        end
      end
      if (i_cmd.set_suspend) begin
        if (conn_now) begin
          st_nxt.suspended = 1'b1;
        end else begin
          st_nxt.chg[0] = 1'b1;
        end
      end
      if (i_cmd.resume && st_r.suspended && st_r.sig == SIG_IDLE) begin
        st_nxt.sig = SIG_RESUME;
        st_nxt.timer = TIMER_W'(RESUME_PULSE_CYCLES);
      end
      if (i_cmd.set_reset) begin
        if (conn_now && st_r.power_on) begin
          st_nxt.reset_active = 1'b1;
          st_nxt.sig = SIG_RESET;
          st_nxt.timer = TIMER_W'(PORT_RESET_CYCLES);
        end else begin
          st_nxt.chg[0] = 1'b1;
        end
      end
    end
    // Power control.
    if (i_cfg.no_power_switch) begin
      st_nxt.power_on = 1'b1;
    end else if (i_line.overcurrent || pwr_off_cmd) begin
      st_nxt.power_on = 1'b0;
    end else if (pwr_on_cmd) begin
      st_nxt.power_on = 1'b1;
    end
    if (!st_nxt.power_on) begin
      if (st_r.enabled) begin
        hw_disable = 1'b1;
      end
      st_nxt.connected = 1'b0;
      st_nxt.suspended = 1'b0;
      st_nxt.reset_active = 1'b0;
      st_nxt.sig = SIG_IDLE;
      st_nxt.low_speed = 1'b0;
    end
    if (hw_disable || !st_nxt.connected) begin
      st_nxt.enabled = 1'b0;
    end
    if (hw_disable) begin
      st_nxt.chg[1] = 1'b1;
    end
    // Software clears; a flag set in this cycle survives the clear.
    if (i_cmd_valid) begin
      chg_keep = chg_keep & ~i_cmd.chg_clear;
    end
    st_nxt.chg = chg_keep | st_nxt.chg;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    o_status = '0;
    o_status[BIT_CONNECTED] = st_r.connected | i_non_removable;
    o_status[BIT_ENABLED] = st_r.enabled;
    o_status[BIT_SUSPENDED] = st_r.suspended;
    o_status[BIT_OVERCURRENT] = st_r.oc;
    o_status[BIT_RESET_ACTIVE] = st_r.reset_active;
    o_status[BIT_POWER_ON] = st_r.power_on | i_cfg.no_power_switch;
    o_status[BIT_LOW_SPEED] = st_r.low_speed;
    o_status[BIT_RESET_DONE_CHG:BIT_CONNECT_CHG] = st_r.chg;
  end

  assign o_drive.drive_reset = (st_r.sig == SIG_RESET);
  assign o_drive.drive_resume = (st_r.sig == SIG_RESUME);
  assign o_drive.drive_ls_eop = (st_r.sig == SIG_RESYNC) && (st_r.timer == TIMER_W'(RESYNC_CYCLES));
  assign o_drive.power_on = st_r.power_on | i_cfg.no_power_switch;
  assign o_drive.enabled = st_r.enabled;
  assign o_drive.suspended = st_r.suspended;

endmodule

/* File: rh_port_ctrl.sv */
// Root hub port register block: access decode, transaction hold-off and port instances.
`timescale 1ns/1ps

module rh_port_ctrl
  import rh_port_pkg::*;
(
  // Clock and reset.
  input  wire logic                  i_mclk,
  input  wire logic                  i_nrst,
  // Register access from the host controller core.
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [31:0]           i_reg_wdata,
  output logic [31:0]                o_reg_rdata,
  output logic                       o_reg_hit,
  // Hub-wide configuration and commands.
  input  wire hub_cfg_s              i_cfg,
  input  wire logic [NUM_PORTS-1:0]  i_power_mask,
  input  wire logic [NUM_PORTS-1:0]  i_non_removable,
  input  wire logic                  i_global_on,
  input  wire logic                  i_global_off,
  input  wire logic                  i_hub_reset_done,
  input  wire logic                  i_hc_resume,
  input  wire logic                  i_xact_busy,
  // Port line state from the transceivers, asynchronous.
  input  wire port_line_s [NUM_PORTS-1:0] i_line,
  // Signalling requests to the transceivers.
  output port_drive_s [NUM_PORTS-1:0] o_drive,
  output logic                       o_write_pending
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    port_line_s [NUM_PORTS-1:0] line_meta;
    port_line_s [NUM_PORTS-1:0] line_sync;
    logic                       pend_valid;
    logic [NUM_PORTS-1:0]       pend_port;
    logic [31:0]                pend_data;
    logic [31:0]                rdata;
    logic                       hit;
  } ctrl_s;

  ctrl_s st_r;
  ctrl_s st_nxt;
  logic [31:0] port_status [NUM_PORTS];
  logic [NUM_PORTS-1:0] cmd_valid;
  logic [NUM_PORTS-1:0] addr_sel;
  port_cmd_s cmd;

  function automatic logic [NUM_PORTS-1:0] port_select(input logic [7:0] addr);
    logic [NUM_PORTS-1:0] sel;
    sel = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (addr == PORT_STATUS_BASE + 8'(p) * PORT_STATUS_STRIDE) begin
        sel[p] = 1'b1;
      end
    end
    return sel;
  endfunction

  assign addr_sel = port_select(i_reg_addr);

  // ****************************************************************
  // Access handling
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.line_meta = i_line;
    st_nxt.line_sync = st_r.line_meta;
    st_nxt.hit = 1'b0;
    // A held write is released once the bus transaction finishes.
    if (st_r.pend_valid && !i_xact_busy) begin
      st_nxt.pend_valid = 1'b0;
    end
    if (i_reg_wr && (addr_sel != '0)) begin
      st_nxt.pend_valid = 1'b1;
      st_nxt.pend_port = addr_sel;
      st_nxt.pend_data = i_reg_wdata;
      st_nxt.hit = 1'b1;
    end
    if (i_reg_rd) begin
      st_nxt.rdata = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (addr_sel[p]) begin
          st_nxt.rdata = port_status[p];
          st_nxt.hit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // A new write that lands on a pending one overwrites it; software is
  // expected to wait, and the last value is the one that takes effect.
  assign cmd = decode_write(st_r.pend_data);
  assign cmd_valid = (st_r.pend_valid && !i_xact_busy) ? st_r.pend_port : '0;

  // ****************************************************************
  // Ports
  // ****************************************************************
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    rh_port_slot u_slot (
      .i_mclk          (i_mclk),
      .i_nrst          (i_nrst),
      .i_cfg           (i_cfg),
      .i_power_mask    (i_power_mask[g]),
      .i_non_removable (i_non_removable[g]),
      .i_hub_reset_done(i_hub_reset_done),
      .i_hc_resume     (i_hc_resume),
      .i_cmd_valid     (cmd_valid[g]),
      .i_cmd           (cmd),
      .i_global_on     (i_global_on),
      .i_global_off    (i_global_off),
      .i_line          (st_r.line_sync[g]),
      .o_status        (port_status[g]),
      .o_drive         (o_drive[g])
    );
  end

  assign o_reg_rdata = st_r.rdata;
  assign o_reg_hit = st_r.hit;
  assign o_write_pending = st_r.pend_valid;

endmodule

/* File: rh_port_ctrl_props.sv */
// Concurrent checks on the ports of the root hub port register block.
`timescale 1ns/1ps
module rh_port_ctrl_chk
  import rh_port_pkg::*;
(
  // Clock and reset.
  input wire logic                        i_mclk,
  input wire logic                        i_nrst,
  // Register access.
  input wire logic                        i_reg_wr,
  input wire logic                        i_reg_rd,
  input wire logic [7:0]                  i_reg_addr,
  input wire logic [31:0]                 i_reg_wdata,
  input wire logic [31:0]                 o_reg_rdata,
  input wire logic                        o_reg_hit,
  // Configuration and port state.
  input wire hub_cfg_s                    i_cfg,
  input wire logic                        i_xact_busy,
  input wire port_line_s [NUM_PORTS-1:0]  i_line,
  input wire port_drive_s [NUM_PORTS-1:0] o_drive,
  input wire logic                        o_write_pending
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  // ****************************************
  // Address decode and write hold-off
  // ****************************************
  logic mapped;
  assign mapped = (i_reg_addr == 8'h54) || (i_reg_addr == 8'h58);

  a_map_hit: assert property ((i_reg_rd || i_reg_wr) && mapped |=> o_reg_hit)
    else $error("mapped access gave no hit");
  a_unmapped_read: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 32'h0 && !o_reg_hit)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (i_reg_rd |=> (o_reg_rdata & 32'hffe0_fce0) == 32'h0)
    else $error("reserved bits read nonzero");
  a_write_held: assert property (i_reg_wr && mapped && i_xact_busy |=> o_write_pending)
    else $error("write during transaction not held");
  a_held_stays: assert property (o_write_pending && i_xact_busy |=> o_write_pending)
    else $error("held write applied during transaction");

  // ****************************************
  // Port power and signalling
  // ****************************************
  a_no_switch_power: assert property (i_cfg.no_power_switch [*3] |-> o_drive[0].power_on && o_drive[1].power_on)
    else $error("power off without power switching");
  a_oc_drops_power: assert property ((!i_cfg.no_power_switch && i_line[0].overcurrent) [*5] |-> !o_drive[0].power_on)
    else $error("power kept under overcurrent");
  a_resume_suspended: assert property ($rose(o_drive[1].drive_resume) |-> $past(o_drive[1].suspended))
    else $error("resume on a port not suspended");
  a_enable_powered: assert property (o_drive[0].enabled |-> o_drive[0].power_on)
    else $error("port enabled without power");
  a_reset_powered: assert property (o_drive[1].drive_reset |-> o_drive[1].power_on)
    else $error("reset signalling without power");
endmodule

bind rh_port_ctrl rh_port_ctrl_chk i_chk (.i_mclk, .i_nrst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .o_reg_hit, .i_cfg, .i_xact_busy, .i_line, .o_drive, .o_write_pending);

/* File: usb_dev_model.sv */
// Downstream device model driving the line state seen by each root port.
`timescale 1ns/1ps
module usb_dev_model
  import rh_port_pkg::*;
(
  // Clock.
  input  wire logic                        i_mclk,
  // Wanted device state and port power.
  input  wire port_line_s [NUM_PORTS-1:0]  i_want,
  input  wire port_drive_s [NUM_PORTS-1:0] i_drive,
  // Line state towards the root hub.
  output port_line_s [NUM_PORTS-1:0]       o_line
);
  // An unpowered device cannot pull up its line, so it reads as detached and the speed line falls low.
  always_ff @(posedge i_mclk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      o_line[p].connected   <= i_want[p].connected & i_drive[p].power_on;
      o_line[p].low_speed   <= i_want[p].connected & i_drive[p].power_on & i_want[p].low_speed;
      o_line[p].overcurrent <= i_want[p].overcurrent;
      o_line[p].bus_error   <= i_want[p].bus_error;
    end
  end
endmodule

/* File: root_hub_port_status_control_bench.sv */
// Self-checking bench for the root hub port status and control block.
`timescale 1ns/1ps
module root_hub_port_status_control_bench;
  import rh_port_pkg::*;
  typedef struct {int op; logic [7:0] a; logic [31:0] d; logic [31:0] m;} row_s;
  logic                        i_mclk, i_nrst, i_reg_wr, i_reg_rd, i_xact_busy;
  logic                        i_global_on, i_global_off, o_reg_hit, o_write_pending;
  logic                        i_hub_reset_done, i_hc_resume, rd_hit;
  logic [7:0]                  i_reg_addr;
  logic [31:0]                 i_reg_wdata, o_reg_rdata, rd_val;
  hub_cfg_s                    i_cfg;
  logic [NUM_PORTS-1:0]        i_power_mask, i_non_removable;
  port_line_s [NUM_PORTS-1:0]  want, line;
  port_drive_s [NUM_PORTS-1:0] o_drive;
  int                          n_fail, tests_run, cyc;
  // Ops: 0 line, 1 write, 2 read, 3 global on, 4 global off, 5 drive/pending, 6 busy level,
  // 7 hub reset done / controller resume pulse, 8 non-removable mask.
  row_s rows[] = '{
    '{2,8'h54,0,'1}, '{2,8'h60,0,'1},
    '{1,8'h54,2,0}, '{2,8'h54,32'h10000,'1}, '{1,8'h54,32'h10000,0}, '{2,8'h54,0,'1},
    '{1,8'h54,32'h100,0}, '{2,8'h54,0,'1}, '{3,0,0,0}, '{2,8'h54,32'h100,'1},
    '{2,8'h58,0,'1}, '{1,8'h58,32'h100,0}, '{2,8'h58,32'h100,'1},
    '{0,1,4'hc,0}, '{2,8'h58,32'h10301,'1}, '{1,8'h58,32'h10002,0},
    '{2,8'h58,32'h303,'1}, '{1,8'h58,1,0}, '{2,8'h58,32'h301,'1},
    '{1,8'h58,4,0}, '{2,8'h58,32'h305,'1}, '{7,0,1,0}, '{2,8'h58,32'h301,'1}, '{1,8'h58,4,0},
    '{1,8'h58,8,0}, '{5,0,32'h400,32'h400},
    '{1,8'h58,32'h200,0}, '{2,8'h58,0,32'hfffefdff},
    '{0,0,4'h8,0}, '{2,8'h54,32'h10101,'1}, '{1,8'h54,32'h10002,0}, '{2,8'h54,32'h103,'1},
    '{0,0,4'ha,0}, '{2,8'h54,32'ha0008,32'hfffefdff}, '{0,0,4'h8,0},
    '{1,8'h54,32'h1f0000,0}, '{2,8'h54,0,32'hfffefdff},
    '{1,8'h54,32'h10,0}, '{2,8'h54,32'h10000,32'h10010}, '{4,0,0,0},
    '{6,0,1,0}, '{1,8'h58,32'h100,0}, '{5,0,32'h1000,32'h1100},
    '{6,0,0,0}, '{5,0,32'h100,32'h1100}, '{0,1,4'hc,0},
    '{1,8'h58,32'h10,0}, '{5,0,32'h800,32'h800}, '{2,8'h58,32'h10,32'h10},
    '{1,8'h54,32'h10000,0}, '{8,0,1,0}, '{2,8'h54,1,32'h10001},
    '{7,0,2,0}, '{2,8'h54,32'h10001,32'h10001}, '{8,0,0,0}
  };

  rh_port_ctrl i_rh_port_ctrl (.i_mclk, .i_nrst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_reg_hit, .i_cfg, .i_power_mask, .i_non_removable, .i_global_on, .i_global_off,
    .i_hub_reset_done, .i_hc_resume, .i_xact_busy, .i_line(line), .o_drive, .o_write_pending);
  usb_dev_model i_usb_dev_model (.i_mclk, .i_want(want), .i_drive(o_drive), .o_line(line));

  initial begin
    i_mclk = 0;
    forever #20 i_mclk = ~i_mclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk) {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
    @(posedge i_mclk) i_reg_wr <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk) {i_reg_rd, i_reg_addr} <= {1'b1, a};
    @(posedge i_mclk) i_reg_rd <= 1'b0;
    #1 rd_val = o_reg_rdata;
    rd_hit = o_reg_hit;
  endtask

  task automatic run(input row_s r);
    case (r.op)
      0: begin
        @(posedge i_mclk) want[r.a[0]] <= port_line_s'(r.d[3:0]);
        repeat (6) @(posedge i_mclk);
      end
      1: wr(r.a, r.d);
      2: begin
        rd(r.a);
        check("status", rd_val & r.m, r.d);
        check("hit", 32'(rd_hit), 32'(r.a == PORT_STATUS_BASE || r.a == PORT_STATUS_BASE + PORT_STATUS_STRIDE));
      end
      3, 4: begin
        @(posedge i_mclk) {i_global_on, i_global_off} <= (r.op == 3) ? 2'b10 : 2'b01;
        @(posedge i_mclk) {i_global_on, i_global_off} <= 2'b00;
        repeat (3) @(posedge i_mclk);
      end
      5: #1 check("drive", 32'({o_write_pending, o_drive}) & r.m, r.d);
      7: begin
        @(posedge i_mclk) {i_hub_reset_done, i_hc_resume} <= r.d[1:0];
        @(posedge i_mclk) {i_hub_reset_done, i_hc_resume} <= 2'b00;
        repeat (3) @(posedge i_mclk);
      end
      8: begin
        @(posedge i_mclk) i_non_removable <= r.d[1:0];
        repeat (3) @(posedge i_mclk);
      end
      default: begin
        @(posedge i_mclk) i_xact_busy <= r.d[0];
        repeat (3) @(posedge i_mclk);
      end
    endcase
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Hang guard
  // ****************************************
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end

  initial begin
    {i_nrst, i_reg_wr, i_reg_rd, i_xact_busy, i_global_on, i_global_off, i_hub_reset_done, i_hc_resume} = '0;
    {i_reg_addr, i_reg_wdata, want, i_non_removable} = '0;
    i_cfg = 4'b0101;
    i_power_mask = 2'b10;
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    foreach (rows[i]) run(rows[i]);
    // Without power switching both ports must read powered whatever software wrote.
    @(posedge i_mclk) i_cfg <= 4'b1101;
    repeat (4) @(posedge i_mclk);
    #1 check("power", 32'({o_drive[1].power_on, o_drive[0].power_on}), 32'h3);
    wr(8'h54, 32'h200);
    rd(8'h54);
    check("power_bit", rd_val & 32'h100, 32'h100);
    // A second reset in mid-run must bring both registers back to zero.
    @(posedge i_mclk) {i_nrst, i_cfg, want} <= {1'b0, 4'b0101, 8'h00};
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(8'h54);
    check("reset_p0", rd_val, PORT_STATUS_RESET);
    rd(8'h58);
    check("reset_p1", rd_val, PORT_STATUS_RESET);
    end_sim;
  end
endmodule
